// [core/brk_mask_pkg.sv]
// Constants shared by the break address mask channel and its comparator.
// Assumes a 32-bit APB register bus and a 32-bit CPU address/data bus.
package brk_mask_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_BREAK_ADDR  = 8'h00; // Break address.
    localparam logic [7:0] OFS_ADDR_MASK   = 8'h04; // Address mask.
    localparam logic [7:0] OFS_BREAK_DATA  = 8'h08; // Break data value.
    localparam logic [7:0] OFS_DATA_MASK   = 8'h0C; // Data mask.
    localparam logic [7:0] OFS_CONTROL     = 8'h10; // Condition enables.
    localparam logic [7:0] OFS_STATUS      = 8'h14; // Sticky events.
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h18; // Interrupt enables.

    // Reset values.
    localparam logic [31:0] RST_WORD       = 32'h00000000;
    localparam logic [5:0]  RST_CONTROL    = 6'h00;

    // Control field positions.
    localparam int CTL_ADDR_EN  = 0; // Address term takes part.
    localparam int CTL_DATA_EN  = 1; // Data term takes part.
    localparam int CTL_ON_READ  = 2; // Break on read accesses.
    localparam int CTL_ON_WRITE = 3; // Break on write accesses.
    localparam int CTL_SIZE_LO  = 4; // Size select, two bits.
    localparam int CTL_WIDTH    = 6;

    // Status and interrupt-mask field positions.
    localparam int STS_HIT      = 0; // A break condition was met.
    localparam int STS_WIDTH    = 1;

    // Size select encodings; any size matches when zero.
    localparam logic [1:0] SIZE_ANY  = 2'h0;

    // True when every unmasked bit of a equals the same bit of b.
    function automatic logic masked_equal(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic [31:0] mask);
        masked_equal = &(~(a ^ b) | mask);
    endfunction

endpackage

// [core/brk_condition.sv]
// Combinational break condition terms for one channel.
// Assumes all inputs are stable within the pclk domain.
module brk_condition #(
    parameter int WIDTH = 32 // Address and data width.
) (
    input  wire logic [WIDTH-1:0] cpu_addr,
    input  wire logic [WIDTH-1:0] cpu_data,
    input  wire logic             cpu_write,
    input  wire logic [1:0]       cpu_size,
    input  wire logic [WIDTH-1:0] break_address_bits,
    input  wire logic [WIDTH-1:0] address_mask_bits,
    input  wire logic [WIDTH-1:0] break_data,
    input  wire logic [WIDTH-1:0] data_mask,
    input  wire logic             on_read,
    input  wire logic             on_write,
    input  wire logic [1:0]       size_sel,
    output logic                  addr_match,
    output logic                  data_match,
    output logic                  type_match,
    output logic                  size_match
);

    // The shared compare function is written for 32-bit words only.
    if (WIDTH != 32) begin : g_width_check
        $error("brk_condition supports WIDTH of 32 only.");
    end

    // Masked positions are ignored; a zero mask bit must compare equal.
    assign addr_match = brk_mask_pkg::masked_equal(cpu_addr,
        break_address_bits, address_mask_bits);
    // The data term uses the same masking so a byte lane can be isolated.
    assign data_match = brk_mask_pkg::masked_equal(cpu_data, break_data,
        data_mask);
    // Access type qualifies the condition by read or write direction.
    assign type_match = cpu_write ? on_write : on_read;
    // A zero size select accepts any access size.
    assign size_match = (size_sel == brk_mask_pkg::SIZE_ANY) ||
                        (size_sel == cpu_size);

endmodule

// [core/break_address_mask_channel.sv]
// One break channel: address mask, break address and data conditions,
// APB register access, a sticky hit flag and a level interrupt.
// Assumes presetn is the power-on reset and the CPU bus is on pclk.
// What this block does
// - Readable and writable 32-bit address mask register.
// - Mask one excludes bit, zero keeps it.
// - Power-on reset clears mask to zero.
// - Manual reset, standby, sleep keep mask.
// - Address, data, type, size form break conditions.
module break_address_mask_channel #(
    parameter int ADDR_W = 32 // CPU address and data width.
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              manual_rst,
    input  wire logic              sleep_mode,
    input  wire logic              standby_mode,
    input  wire logic              cpu_valid,
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic [ADDR_W-1:0] cpu_data,
    input  wire logic              cpu_write,
    input  wire logic [1:0]        cpu_size,
    output logic                   break_hit,
    output logic                   irq
);

    // The register map holds exactly one 32-bit word per register.
    if (ADDR_W != 32) begin : g_width_check
        $error("break_address_mask_channel supports ADDR_W of 32 only.");
    end

    logic [31:0] break_address_mask_ch2_q; // Address mask bits.
    logic [31:0] break_addr_q;             // Break address bits.
    logic [31:0] break_data_q;             // Break data value.
    logic [31:0] data_mask_q;              // Data mask bits.
    logic [brk_mask_pkg::CTL_WIDTH-1:0] control_q; // Condition enables.
    logic [brk_mask_pkg::STS_WIDTH-1:0] status_q;  // Sticky events.
    logic [brk_mask_pkg::STS_WIDTH-1:0] irq_mask_q; // Interrupt enables.
    logic [31:0] prdata_q;                 // Read data held for the bus.
    logic        pready_q;                 // Access phase answer.
    logic        pslverr_q;                // Unmapped address answer.
    logic        break_hit_q;              // One-cycle hit pulse.
    logic        irq_q;                    // Registered interrupt level.
    logic        addr_match;               // Masked address comparison.
    logic        data_match;               // Masked data comparison.
    logic        type_match;               // Direction qualifies.
    logic        size_match;               // Size qualifies.
    logic        hit_d;                    // Condition met this cycle.
    logic        wr_done;                  // Write completes this edge.
    logic        rd_setup;                 // First access cycle of a read.
    logic [31:0] rd_word;                  // Decoded read value.
    logic        addr_ok;                  // Address hits a register.

    // A write takes effect only at the edge where pready is sampled high.
    assign wr_done  = ce && psel && penable && pready_q && pwrite;
    assign rd_setup = ce && psel && penable && !pready_q && !pwrite;

    // Comparator for address, data, direction and size terms.
    brk_condition #(
        .WIDTH(ADDR_W)
    ) u_cond (
        .cpu_addr          (cpu_addr),
        .cpu_data          (cpu_data),
        .cpu_write         (cpu_write),
        .cpu_size          (cpu_size),
        .break_address_bits(break_addr_q),
        .address_mask_bits (break_address_mask_ch2_q),
        .break_data        (break_data_q),
        .data_mask         (data_mask_q),
        .on_read           (control_q[brk_mask_pkg::CTL_ON_READ]),
        .on_write          (control_q[brk_mask_pkg::CTL_ON_WRITE]),
        .size_sel          (control_q[brk_mask_pkg::CTL_SIZE_LO +: 2]),
        .addr_match        (addr_match),
        .data_match        (data_match),
        .type_match        (type_match),
        .size_match        (size_match)
    );

    // A channel with neither term enabled never breaks, which keeps a
    // freshly reset channel quiet until software arms it.
    always_comb begin
        hit_d = cpu_valid && type_match && size_match &&
            (control_q[brk_mask_pkg::CTL_ADDR_EN] ||
             control_q[brk_mask_pkg::CTL_DATA_EN]) &&
            (!control_q[brk_mask_pkg::CTL_ADDR_EN] || addr_match) &&
            (!control_q[brk_mask_pkg::CTL_DATA_EN] || data_match);
    end

    // Read decode; unmapped addresses read zero and flag an error.
    always_comb begin
        rd_word = brk_mask_pkg::RST_WORD;
        addr_ok = 1'b1;
        if (paddr == brk_mask_pkg::OFS_BREAK_ADDR) begin
            rd_word = break_addr_q;
        end else if (paddr == brk_mask_pkg::OFS_ADDR_MASK) begin
            rd_word = break_address_mask_ch2_q;
        end else if (paddr == brk_mask_pkg::OFS_BREAK_DATA) begin
            rd_word = break_data_q;
        end else if (paddr == brk_mask_pkg::OFS_DATA_MASK) begin
            rd_word = data_mask_q;
        end else if (paddr == brk_mask_pkg::OFS_CONTROL) begin
            rd_word = {26'h0000000, control_q};
        end else if (paddr == brk_mask_pkg::OFS_STATUS) begin
            rd_word = {31'h0000000, status_q};
        end else if (paddr == brk_mask_pkg::OFS_IRQ_MASK) begin
            rd_word = {31'h0000000, irq_mask_q};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // APB answer: one wait cycle, then pready with data and error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= brk_mask_pkg::RST_WORD;
        end else if (ce) begin
            // The answer drops after one cycle so the master can release.
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_ok;
            if (rd_setup) begin
                prdata_q <= rd_word;
            end
        end
    end

    // The mask sees only the power-on reset; manual reset, sleep and
    // standby are deliberately not wired in so the value survives them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_address_mask_ch2_q <= brk_mask_pkg::RST_WORD;
        end else if (wr_done && paddr == brk_mask_pkg::OFS_ADDR_MASK) begin
            break_address_mask_ch2_q <= pwdata;
        end
    end

    // The other condition registers follow the same retention policy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_addr_q <= brk_mask_pkg::RST_WORD;
            break_data_q <= brk_mask_pkg::RST_WORD;
            data_mask_q  <= brk_mask_pkg::RST_WORD;
            control_q    <= brk_mask_pkg::RST_CONTROL;
            irq_mask_q   <= '0;
        end else if (wr_done) begin
            if (paddr == brk_mask_pkg::OFS_BREAK_ADDR) begin
                break_addr_q <= pwdata;
            end else if (paddr == brk_mask_pkg::OFS_BREAK_DATA) begin
                break_data_q <= pwdata;
            end else if (paddr == brk_mask_pkg::OFS_DATA_MASK) begin
                data_mask_q <= pwdata;
            end else if (paddr == brk_mask_pkg::OFS_CONTROL) begin
                control_q <= pwdata[brk_mask_pkg::CTL_WIDTH-1:0];
            end else if (paddr == brk_mask_pkg::OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[brk_mask_pkg::STS_WIDTH-1:0];
            end
        end
    end

    // Sticky hit flag: a new hit wins over a write-one clear in the same
    // cycle, so no event is lost. A manual reset clears the flag only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (ce) begin
            if (hit_d) begin
                status_q[brk_mask_pkg::STS_HIT] <= 1'b1;
            end else if (manual_rst) begin
                status_q <= '0;
            end else if (wr_done && paddr == brk_mask_pkg::OFS_STATUS) begin
                status_q <= status_q & ~pwdata[brk_mask_pkg::STS_WIDTH-1:0];
            end
        end
    end

    // Hit pulse and interrupt level, both registered for clean outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_hit_q <= 1'b0;
            irq_q       <= 1'b0;
        end else if (ce) begin
            break_hit_q <= hit_d;
            irq_q       <= |(status_q & irq_mask_q);
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign break_hit = break_hit_q;
    assign irq       = irq_q;

    // A completed mask write shows up in the register one edge later.
    a_mask_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_done && paddr == brk_mask_pkg::OFS_ADDR_MASK
        |=> break_address_mask_ch2_q == $past(pwdata))
        else $error("Mask write did not land.");

    // A mask read returns the mask held when the access began.
    a_mask_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == brk_mask_pkg::OFS_ADDR_MASK
        |=> pready_q && prdata_q == $past(break_address_mask_ch2_q))
        else $error("Mask read returned wrong data.");

    // Address-only breaks follow the masked comparison exactly.
    a_masked_compare: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && cpu_valid && type_match && size_match &&
        control_q == 6'h0D
        |=> break_hit_q == ((($past(cpu_addr) ^ $past(break_addr_q)) &
            ~$past(break_address_mask_ch2_q)) == 32'h00000000))
        else $error("Masked address compare mismatch.");

    // Leaving power-on reset the mask reads zero.
    a_poweron_clear: assert property (@(posedge pclk)
        $rose(presetn) |-> break_address_mask_ch2_q == 32'h00000000)
        else $error("Mask not cleared by power-on reset.");

    // Manual reset, sleep and standby leave the mask untouched.
    a_mask_retain: assert property (
        @(posedge pclk) disable iff (!presetn)
        (manual_rst || sleep_mode || standby_mode) &&
        !(wr_done && paddr == brk_mask_pkg::OFS_ADDR_MASK)
        |=> $stable(break_address_mask_ch2_q))
        else $error("Mask changed without a write.");

    // An enabled data term that mismatches blocks the break.
    a_data_qualify: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && control_q[brk_mask_pkg::CTL_DATA_EN] && !data_match
        |=> !break_hit_q)
        else $error("Break taken on data mismatch.");

    // A valid unmasked address mismatch never breaks on address.
    a_addr_qualify: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && control_q[brk_mask_pkg::CTL_ADDR_EN] && !addr_match
        |=> !break_hit_q ##1 1'b1)
        else $error("Break taken on address mismatch.");

    // The interrupt follows an unmasked sticky hit within one cycle.
    a_irq_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && hit_d && irq_mask_q[brk_mask_pkg::STS_HIT] ##1 ce
        |=> irq_q)
        else $error("Interrupt did not follow hit.");

endmodule

// [testbench/testbench.sv]
// Self-checking bench for one break channel: mask register, match logic,
// sticky hit status and its level interrupt, set up over APB and driven from the CPU bus, with break_hit and irq checked at their ports.
// Assumes the design answers APB with wait states and asserts its own checks.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, ce, psel, penable, pwrite;  // Clock and bus.
    logic [7:0]  paddr;                                     // Byte address.
    logic [31:0] pwdata, prdata;                            // Bus data.
    logic        pready, pslverr, break_hit, irq;           // Answers.
    logic        manual_rst, sleep_mode, standby_mode;      // Power states.
    logic        cpu_valid, cpu_write;                      // CPU access.
    logic [31:0] cpu_addr, cpu_data;                        // CPU bus.
    logic [1:0]  cpu_size;                                  // CPU access size.
    logic [31:0] rd;                                        // Last read data.
    logic        err;                                       // Last error flag.
    int          failures, samples_checked, cycles;         // Bookkeeping.
    logic [31:0] pat [4] = '{32'hFFFF_FFFF, 32'hA5A5_5A5A, 32'h0000_0001,
                             32'h8000_0000};               // Mask patterns.
    int          bits [4] = '{0, 7, 8, 31};                 // Probed bits.

    break_address_mask_channel #(.ADDR_W(32)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .manual_rst(manual_rst), .sleep_mode(sleep_mode),
        .standby_mode(standby_mode), .cpu_valid(cpu_valid),
        .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_write(cpu_write),
        .cpu_size(cpu_size), .break_hit(break_hit), .irq(irq));

    // Free-running 40 MHz clock.
    always #12.5 pclk = ~pclk;

    // Prints the counts and the verdict, then stops the run.
    task automatic finish_test;
        $display("Checks: %0d, failures: %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang in a handshake wait is cut short here and counted.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Reads a register and checks both the data and the error response.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input logic exp_err);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, exp_err});
    endtask

    // Builds a control word from its enables and size select.
    function automatic logic [31:0] ctl(input logic a, d, r, w,
                                        input logic [1:0] sz);
        ctl = 32'h0;
        ctl[brk_mask_pkg::CTL_ADDR_EN] = a;
        ctl[brk_mask_pkg::CTL_DATA_EN] = d;
        ctl[brk_mask_pkg::CTL_ON_READ] = r;
        ctl[brk_mask_pkg::CTL_ON_WRITE] = w;
        ctl[brk_mask_pkg::CTL_SIZE_LO +: 2] = sz;
    endfunction

    // One CPU access; the hit pulse is looked at in the cycle after it.
    task automatic cpu(input logic [31:0] a, input logic [31:0] d,
                       input logic w, input logic [1:0] sz, input logic exp);
        @(posedge pclk);
        cpu_valid <= 1'h1;
        cpu_addr <= a;
        cpu_data <= d;
        cpu_write <= w;
        cpu_size <= sz;
        @(posedge pclk);
        cpu_valid <= 1'h0;
        @(posedge pclk);
        check({31'h0, break_hit}, {31'h0, exp});
    endtask

    // Holds power-on reset for five cycles, then releases it.
    task automatic por;
        presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    initial begin
        {pclk, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        {manual_rst, sleep_mode, standby_mode, cpu_valid, cpu_write} = '0;
        {cpu_addr, cpu_data, cpu_size, failures, samples_checked} = '0;
        cycles = 0;
        presetn = 1'h0;
        ce = 1'h1;
        por();
        rdchk(brk_mask_pkg::OFS_ADDR_MASK, 32'h0, 1'h0);
        rdchk(8'h1C, 32'h0, 1'h1);
        // Every pattern must read back as written.
        foreach (pat[i]) begin
            apb(1'h1, brk_mask_pkg::OFS_ADDR_MASK, pat[i]);
            rdchk(brk_mask_pkg::OFS_ADDR_MASK, pat[i], 1'h0);
        end
        // Manual reset and the low-power states must keep the mask.
        apb(1'h1, brk_mask_pkg::OFS_ADDR_MASK, 32'h0000_00FF);
        @(posedge pclk) {manual_rst, sleep_mode, standby_mode} <= 3'h7;
        repeat (3) @(posedge pclk);
        {manual_rst, sleep_mode, standby_mode} <= 3'h0;
        rdchk(brk_mask_pkg::OFS_ADDR_MASK, 32'h0000_00FF, 1'h0);
        apb(1'h1, brk_mask_pkg::OFS_BREAK_ADDR, 32'h1234_5678);
        apb(1'h1, brk_mask_pkg::OFS_CONTROL, ctl(1, 0, 1, 1, 2'h0));
        apb(1'h1, brk_mask_pkg::OFS_IRQ_MASK, 32'h1);
        cpu(32'h1234_5678, 32'h0, 1'h0, 2'h0, 1'h1);
        // A flipped bit misses unless its mask bit is one.
        foreach (bits[i]) begin
            cpu(32'h1234_5678 ^ (32'h1 << bits[i]), 32'h0, 1'h1, 2'h0,
                bits[i] < 8);
        end
        rdchk(brk_mask_pkg::OFS_STATUS, 32'h1, 1'h0);
        check({31'h0, irq}, 32'h1);
        apb(1'h1, brk_mask_pkg::OFS_STATUS, 32'h1);
        rdchk(brk_mask_pkg::OFS_STATUS, 32'h0, 1'h0);
        check({31'h0, irq}, 32'h0);
        // A masked-out event stays in status but raises no interrupt.
        apb(1'h1, brk_mask_pkg::OFS_IRQ_MASK, 32'h0);
        cpu(32'h1234_56AB, 32'h0, 1'h0, 2'h0, 1'h1);
        rdchk(brk_mask_pkg::OFS_STATUS, 32'h1, 1'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'h1, brk_mask_pkg::OFS_ADDR_MASK, 32'h0);
        cpu(32'h1234_5679, 32'h0, 1'h0, 2'h0, 1'h0);
        // Data term with its own mask, then access type and size.
        apb(1'h1, brk_mask_pkg::OFS_BREAK_DATA, 32'hCAFE_0000);
        apb(1'h1, brk_mask_pkg::OFS_DATA_MASK, 32'h0000_FFFF);
        apb(1'h1, brk_mask_pkg::OFS_CONTROL, ctl(0, 1, 1, 1, 2'h0));
        cpu(32'h0, 32'hCAFE_1234, 1'h1, 2'h0, 1'h1);
        cpu(32'h0, 32'hCAFF_1234, 1'h1, 2'h0, 1'h0);
        apb(1'h1, brk_mask_pkg::OFS_CONTROL, ctl(1, 0, 1, 0, 2'h2));
        cpu(32'h1234_5678, 32'h0, 1'h0, 2'h2, 1'h1);
        cpu(32'h1234_5678, 32'h0, 1'h1, 2'h2, 1'h0);
        cpu(32'h1234_5678, 32'h0, 1'h0, 2'h1, 1'h0);
        // With the clock enable low a matching access must leave no trace.
        ce <= 1'h0;
        cpu(32'h1234_5678, 32'h0, 1'h0, 2'h2, 1'h0);
        ce <= 1'h1;
        cpu(32'h1234_5678, 32'h0, 1'h0, 2'h2, 1'h1);
        // A second power-on reset in mid-run clears the mask again.
        apb(1'h1, brk_mask_pkg::OFS_ADDR_MASK, 32'hA5A5_5A5A);
        @(posedge pclk);
        por();
        rdchk(brk_mask_pkg::OFS_ADDR_MASK, 32'h0, 1'h0);
        finish_test();
    end
endmodule
